// File: test/dac_host_model.sv
// host serial master model that loads frames into the converter
// assumes the 100 MHz reference; pins move on its falling edge
module dac_host_model (
    input  wire logic i_ref_clk,
    output logic      o_sclk,
    output logic      o_sdi,
    output logic      o_load_strobe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // frame driver, 80 ns serial clock
    // ----
    initial begin
        o_sclk = 1'b0;
        o_sdi = 1'b1;
        o_load_strobe_n = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask : hold
    // single device, so 24-bit frames are allowed
    task automatic send_frame(input logic [31:0] w, input int nbits);
        o_load_strobe_n = 1'b0;
        hold(4);
        for (int i = nbits - 1; i >= 0; i--) begin
            o_sdi = w[i];
            hold(4);
            o_sclk = 1'b1;
            hold(4);
            o_sclk = 1'b0;
        end
        hold(4);
        o_load_strobe_n = 1'b1;
        o_sdi = ~o_sdi;
    endtask : send_frame
endmodule : dac_host_model

// File: test/dac_serial_command_loader_tb_top.sv
// self-checking bench of the serial command loader
// assumes dac_loader_pkg and the host model are compiled first
module dac_serial_command_loader_tb_top
    import dac_loader_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_ref_clk = 1'b0;
    logic        i_arst_n = 1'b0;
    logic        i_async_clear_n = 1'b1;
    logic [1:0]  i_resolution = 2'h0;
    wire logic   sclk;
    wire logic   sdi;
    wire logic   strobe_n;
    logic        o_sdo;
    logic        o_bipolar;
    logic        o_update;
    logic [15:0] o_dac_code;
    logic [3:0]  o_range_cmd;
    logic [31:0] seed = 32'he464;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          upd_cnt;
    // ----
    // instances and clock
    // ----
    dac_host_model host_u (.i_ref_clk(i_ref_clk), .o_sclk(sclk), .o_sdi(sdi), .o_load_strobe_n(strobe_n));
    dac_serial_command_loader dut_u (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_async_clear_n(i_async_clear_n),
        .i_load_strobe_n(strobe_n), .i_sclk(sclk), .i_sdi(sdi), .i_resolution(i_resolution), .o_sdo(o_sdo),
        .o_dac_code(o_dac_code), .o_range_cmd(o_range_cmd), .o_bipolar(o_bipolar), .o_update(o_update));
    always #5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    // ----
    // helpers
    // ----
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [15:0] masked(input logic [15:0] d, input logic [1:0] r);
        return d & ((r == RES_14) ? MASK_14 : (r == RES_12) ? MASK_12 : MASK_16);
    endfunction : masked
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic frame(input logic [31:0] w, input int n);
        upd_cnt = 0;
        host_u.send_frame(w, n);
        repeat (12) begin
            @(negedge i_ref_clk);
            if (o_update === 1'b1) upd_cnt++;
        end
    endtask : frame
    task automatic end_of_test();
        $display("checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    // ----
    // scenarios
    // ----
    initial begin
        logic [15:0] d;
        logic [3:0]  c;
        repeat (12) @(negedge i_ref_clk);
        i_arst_n = 1'b1;
        repeat (6) @(negedge i_ref_clk);
        chk({o_bipolar, o_range_cmd}, {1'b0, RANGE_RESET});
        chk(o_dac_code, CODE_RESET);
        frame({8'h00, CMD_RNG_U10, 4'h5, 16'h0000}, 24);
        chk({o_bipolar, o_range_cmd, o_dac_code}, 32'h0009_0000);
        chk(upd_cnt, 1);
        frame({8'h00, CMD_RNG_B5, 4'ha, 16'h8000}, 24);
        chk({o_bipolar, o_range_cmd, o_dac_code}, 32'h001a_8000);
        for (int k = 0; k < 12; k++) begin
            seed = xs(seed);
            c = CMD_RNG_U5 + 4'(k % 6);
            i_resolution = seed[25:24];
            d = seed[15:0];
            frame({seed[31:24], c, seed[23:20], d}, 32);
            chk(o_range_cmd, c);
            chk(o_bipolar, c[1] | c[2]);
            chk(o_dac_code, masked(d, seed[25:24]));
            chk(o_sdo, seed[31]);
        end
        i_resolution = RES_16;
        frame({8'h00, CMD_LOAD_IN, 4'h0, 16'h1234}, 24);
        chk(o_dac_code, masked(d, seed[25:24]));
        frame({8'h00, CMD_UPDATE, 4'h0, 16'hffff}, 24);
        chk({o_range_cmd, o_dac_code}, {12'h0, c, 16'h1234});
        chk(upd_cnt, 1);
        frame({8'h00, CMD_LOAD_BOTH, 4'h0, 16'hbeef}, 24);
        chk({o_range_cmd, o_dac_code}, {12'h0, c, 16'hbeef});
        for (int k = 0; k < 3; k++) begin
            frame({8'h00, (k == 0) ? 4'h3 : (k == 1) ? 4'he : CMD_NOP, 4'h0, 16'h0f0f}, 24);
            chk({upd_cnt[3:0], o_range_cmd, o_dac_code}, {8'h0, c, 16'hbeef});
        end
        i_async_clear_n = 1'b0;
        repeat (5) @(negedge i_ref_clk);
        i_async_clear_n = 1'b1;
        repeat (4) @(negedge i_ref_clk);
        chk({o_sdo, o_dac_code}, 32'h0);
        frame({8'h00, CMD_UPDATE, 4'h0, 16'h5555}, 24);
        chk(o_dac_code, 16'h0000);
        end_of_test();
    end
endmodule : dac_serial_command_loader_tb_top

// File: verilog/dac_loader_pkg.sv
// package for the serial command loader of a range-programmable converter
// assumes one system clock; all serial pins are asynchronous to it
package dac_loader_pkg;
    localparam int          SHIFT_W        = 32;
    localparam int          CODE_W         = 16;
    localparam int          CMD_MSB        = 23;
    localparam int          CMD_LSB        = 20;
    localparam logic [3:0]  CMD_LOAD_IN    = 4'h0;
    localparam logic [3:0]  CMD_UPDATE     = 4'h1;
    localparam logic [3:0]  CMD_LOAD_BOTH  = 4'h2;
    localparam logic [3:0]  CMD_RNG_U5     = 4'h8;
    localparam logic [3:0]  CMD_RNG_U10    = 4'h9;
    localparam logic [3:0]  CMD_RNG_B5     = 4'ha;
    localparam logic [3:0]  CMD_RNG_B10    = 4'hb;
    localparam logic [3:0]  CMD_RNG_B2P5   = 4'hc;
    localparam logic [3:0]  CMD_RNG_OFS    = 4'hd;
    localparam logic [3:0]  CMD_NOP        = 4'hf;
    localparam logic [3:0]  RANGE_RESET    = 4'h8;
    localparam logic [15:0] CODE_RESET     = 16'h0000;
    localparam logic [31:0] SHIFT_RESET    = 32'h0000_0000;
    localparam logic [1:0]  RES_16         = 2'h0;
    localparam logic [1:0]  RES_14         = 2'h1;
    localparam logic [1:0]  RES_12         = 2'h2;
    localparam logic [15:0] MASK_14        = 16'hfffc;
    localparam logic [15:0] MASK_12        = 16'hfff0;
    localparam logic [15:0] MASK_16        = 16'hffff;

    typedef struct packed {
        logic [3:0]  range_cmd;
        logic        bipolar;
        logic [15:0] code;
    } dac_state_s;
endpackage : dac_loader_pkg

// File: verilog/dac_serial_command_loader.sv
// serial load and command execution for a range-programmable converter
// assumes serial pins and clear are asynchronous to i_ref_clk and are
// synchronised here; serial clock must be far slower than i_ref_clk
module dac_serial_command_loader
    import dac_loader_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_async_clear_n,
    input  wire logic        i_load_strobe_n,
    input  wire logic        i_sclk,
    input  wire logic        i_sdi,
    input  wire logic [1:0]  i_resolution,
    output logic             o_sdo,
    output logic [15:0]      o_dac_code,
    output logic [3:0]       o_range_cmd,
    output logic             o_bipolar,
    output logic             o_update
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [1:0] clr_sync_r;
    logic [1:0] cs_sync_r;
    logic [1:0] sck_sync_r;
    logic [1:0] sdi_sync_r;
    logic [1:0] res_meta_r;
    logic [1:0] res_sync_r;
    logic       sck_prev_r;
    logic       cs_prev_r;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            clr_sync_r <= 2'h0;
            cs_sync_r  <= 2'h3;
            sck_sync_r <= 2'h0;
            sdi_sync_r <= 2'h0;
            res_meta_r <= RES_16;
            res_sync_r <= RES_16;
            sck_prev_r <= 1'b0;
            cs_prev_r  <= 1'b1;
        end else begin
            clr_sync_r <= {clr_sync_r[0], i_async_clear_n};
            cs_sync_r  <= {cs_sync_r[0], i_load_strobe_n};
            sck_sync_r <= {sck_sync_r[0], i_sclk};
            sdi_sync_r <= {sdi_sync_r[0], i_sdi};
            res_meta_r <= i_resolution;
            res_sync_r <= res_meta_r;
            sck_prev_r <= sck_sync_r[1];
            cs_prev_r  <= cs_sync_r[1];
        end
    end

    logic clear_n;
    logic sck_rise;
    logic cs_rise;
    assign clear_n  = clr_sync_r[1];
    assign sck_rise = sck_sync_r[1] & ~sck_prev_r;
    assign cs_rise  = cs_sync_r[1] & ~cs_prev_r;

    // ------------------------------------------------------------
    // shift register
    // ------------------------------------------------------------
    logic [SHIFT_W-1:0] input_shift_reg_r;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            input_shift_reg_r <= SHIFT_RESET;
        end else if (!clear_n) begin
            input_shift_reg_r <= SHIFT_RESET;
        end else if (sck_rise && !cs_sync_r[1]) begin
            input_shift_reg_r <= {input_shift_reg_r[SHIFT_W-2:0], sdi_sync_r[1]};
        end
    end

    assign o_sdo = input_shift_reg_r[SHIFT_W-1];

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic [3:0]  command_nibble;
    logic [15:0] data_word;
    logic [15:0] res_mask;
    logic [15:0] masked_word;
    assign command_nibble = input_shift_reg_r[CMD_MSB:CMD_LSB];
    assign data_word      = input_shift_reg_r[CODE_W-1:0];

    always_comb begin
        case (res_sync_r)
            RES_14:  res_mask = MASK_14;
            RES_12:  res_mask = MASK_12;
            default: res_mask = MASK_16;
        endcase
    end

    assign masked_word = data_word & res_mask;

    logic [15:0] in_buf_r;
    logic [15:0] dac_buf_r;
    logic [3:0]  range_r;
    logic        update_r;

    // ------------------------------------------------------------
    // execution on strobe rising edge
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            in_buf_r  <= CODE_RESET;
            dac_buf_r <= CODE_RESET;
            range_r   <= RANGE_RESET;
            update_r  <= 1'b0;
        end else if (!clear_n) begin
            in_buf_r  <= CODE_RESET;
            dac_buf_r <= CODE_RESET;
            update_r  <= 1'b0;
        end else begin
            update_r <= 1'b0;
            if (cs_rise) begin
                case (command_nibble)
                    CMD_LOAD_IN: begin
                        in_buf_r <= masked_word;
                    end
                    CMD_UPDATE: begin
                        dac_buf_r <= in_buf_r;
                        update_r  <= 1'b1;
                    end
                    CMD_LOAD_BOTH: begin
                        in_buf_r  <= masked_word;
                        dac_buf_r <= masked_word;
                        update_r  <= 1'b1;
                    end
                    CMD_RNG_U5, CMD_RNG_U10, CMD_RNG_B5, CMD_RNG_B10, CMD_RNG_B2P5, CMD_RNG_OFS: begin
                        range_r   <= command_nibble;
                        in_buf_r  <= masked_word;
                        dac_buf_r <= masked_word;
                        update_r  <= 1'b1;
                    end
                    default: begin
                        update_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    dac_state_s state;
    assign state = '{range_cmd: range_r, bipolar: range_r[1] | range_r[2], code: dac_buf_r};

    assign o_dac_code  = state.code;
    assign o_range_cmd = state.range_cmd;
    assign o_bipolar   = state.bipolar;
    assign o_update    = update_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_shift_in;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (sck_rise && !cs_sync_r[1] && clear_n) |=> input_shift_reg_r[0] == $past(sdi_sync_r[1]);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("shift bit not captured");

    property p_hold_when_cs_high;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (cs_sync_r[1] && clear_n) |=> $stable(input_shift_reg_r) || !clear_n;
    endproperty
    a_hold_when_cs_high: assert property (p_hold_when_cs_high) else $error("shift while strobe high");

    property p_sdo;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (sck_rise && !cs_sync_r[1] && clear_n) |=> o_sdo == $past(input_shift_reg_r[SHIFT_W-2]);
    endproperty
    a_sdo: assert property (p_sdo) else $error("serial out wrong");

    property p_clear;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        !clear_n |=> (o_dac_code == CODE_RESET) && (input_shift_reg_r == SHIFT_RESET);
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero");

    property p_range_set;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (cs_rise && clear_n && command_nibble[3] && command_nibble != CMD_NOP && command_nibble != 4'he)
        |=> o_range_cmd == $past(command_nibble) && o_dac_code == $past(masked_word);
    endproperty
    a_range_set: assert property (p_range_set) else $error("range command not applied");

    property p_range_keep;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        !(cs_rise && command_nibble[3]) |=> $stable(o_range_cmd);
    endproperty
    a_range_keep: assert property (p_range_keep) else $error("range changed without command");

    property p_bipolar_b5;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (o_range_cmd == CMD_RNG_B5) |-> o_bipolar;
    endproperty
    a_bipolar_b5: assert property (p_bipolar_b5) else $error("bipolar flag missing");

    property p_unipolar_u10;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (o_range_cmd == CMD_RNG_U10 || o_range_cmd == CMD_RNG_U5) |-> !o_bipolar;
    endproperty
    a_unipolar_u10: assert property (p_unipolar_u10) else $error("unipolar flag wrong");

    property p_mask12;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (res_sync_r == RES_12 && $stable(res_sync_r) && o_update) |-> o_dac_code[3:0] == 4'h0;
    endproperty
    a_mask12: assert property (p_mask12) else $error("12-bit low bits not ignored");

    property p_mask14;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (res_sync_r == RES_14 && $stable(res_sync_r) && o_update) |-> o_dac_code[1:0] == 2'h0;
    endproperty
    a_mask14: assert property (p_mask14) else $error("14-bit low bits not ignored");

    c_range_b5: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n) cs_rise && command_nibble == CMD_RNG_B5);
    c_update:   cover property (@(posedge i_ref_clk) disable iff (!i_arst_n) cs_rise && command_nibble == CMD_UPDATE);
    c_clear:    cover property (@(posedge i_ref_clk) disable iff (!i_arst_n) !clear_n ##1 clear_n);
endmodule : dac_serial_command_loader
